// ---- inc/vid_pkg.sv ----
// types shared by the identification register group.
// constants live in vid_regs.svh.
package vid_pkg;

  typedef enum logic [0:0] {
    VID_ST_LOAD = 1'b0,
    VID_ST_RUN = 1'b1
  } vid_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } vid_bus_req_t;

  typedef struct packed {
    logic en;
    logic [3:0] idx;
    logic [31:0] data;
  } vid_store_wr_t;

endpackage

// ---- inc/vid_regs.svh ----
// register offsets, indices, field layouts and reset values of the
// identification and version word group.
// assumes 32-bit byte addressing with one aligned word per register.
`ifndef VID_REGS_SVH
`define VID_REGS_SVH

`define VID_ADDR_W 32
`define VID_DATA_W 32
`define VID_IDX_W 4
`define VID_DEPTH 12
`define VID_LOAD_LAST 4'h9

// byte addresses
`define VID_BASE_ADDR 32'hF1000010
`define VID_CTRL_VER_ADDR 32'hF1000010
`define VID_CTRL_VER_EX_ADDR 32'hF1000014
`define VID_LOGIC_VER_ADDR 32'hF1000018
`define VID_LOGIC_VER_EX_ADDR 32'hF100001C
`define VID_RSVD_A_ADDR 32'hF1000020
`define VID_RSVD_B_ADDR 32'hF1000024
`define VID_RSVD_C_ADDR 32'hF1000028
`define VID_RSVD_D_ADDR 32'hF100002C
`define VID_ORDER_HI_ADDR 32'hF1000030
`define VID_ORDER_LO_ADDR 32'hF1000034
`define VID_FEAT_CTRL_ADDR 32'hF1000050
`define VID_STATUS_ADDR 32'hF1000054

// word indices inside the store
`define VID_IDX_CTRL_VER 4'h0
`define VID_IDX_CTRL_VER_EX 4'h1
`define VID_IDX_LOGIC_VER 4'h2
`define VID_IDX_LOGIC_VER_EX 4'h3
`define VID_IDX_RSVD_A 4'h4
`define VID_IDX_RSVD_B 4'h5
`define VID_IDX_RSVD_C 4'h6
`define VID_IDX_RSVD_D 4'h7
`define VID_IDX_ORDER_HI 4'h8
`define VID_IDX_ORDER_LO 4'h9
`define VID_IDX_FEAT_CTRL 4'hA
`define VID_IDX_STATUS 4'hB

// field layout: type code in the upper half, version in the lower half
`define VID_TYPE_MSB 31
`define VID_TYPE_LSB 16
`define VID_VER_MSB 15
`define VID_VER_LSB 0
`define VID_CTRL_TYPE_CODE 16'h0000

// feature control word
`define VID_FEAT_PRESENT_BIT 0
`define VID_FEAT_ENABLE_BIT 1
`define VID_FEAT_CTRL_RESET 32'h00000001

// status word
`define VID_ST_CTRL_VER_OK 0
`define VID_ST_LOGIC_VER_OK 1
`define VID_ST_CTRL_EX_OK 2
`define VID_ST_LOGIC_EX_OK 3
`define VID_ST_CTRL_EX_SUP 4
`define VID_ST_LOGIC_EX_SUP 5
`define VID_ST_LOADED 6
`define VID_ST_FEAT_EN 7
`define VID_STATUS_RESET 32'h00000000

`define VID_ZERO_WORD 32'h00000000
`define VID_NIBBLE_MAX 4'h9

`endif

// ---- src/vid_regs_top.sv ----
// identification and version register group of a camera controller.
// assumes a simple strobe bus: one-cycle wr or rd, read data next cycle.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`include "vid_regs.svh"

module vid_regs_top
  import vid_pkg::*;
#(
  parameter logic [15:0] CTRL_VERSION = 16'h0100,
  parameter logic [31:0] CTRL_VERSION_EX = 32'h00010000,
  // arbitrary neutral value, not a real model code
  parameter logic [15:0] CAMERA_TYPE = 16'h0ABC,
  parameter logic [15:0] LOGIC_VERSION = 16'h0200,
  parameter logic [31:0] LOGIC_VERSION_EX = 32'h00020000,
  // arbitrary ASCII text "ORDER-01"
  parameter logic [63:0] ORDER_ID = 64'h4F524445522D3031
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register bus
  input wire vid_bus_req_t bus_req,
  output logic [`VID_DATA_W-1:0] bus_rdata,
  // status
  output logic loaded,
  output logic feature_enabled
);

  vid_state_t state_r;
  vid_state_t state_nxt;
  logic [`VID_IDX_W-1:0] load_idx_r;
  logic loaded_r;
  logic feat_en_r;
  logic [`VID_DATA_W-1:0] status_r;
  logic [`VID_DATA_W-1:0] status_nxt;
  logic status_dirty_r;
  logic status_wr_go;
  logic feat_seeded_r;

  logic [`VID_IDX_W-1:0] dec_idx;
  logic dec_hit;
  logic dec_rsvd;
  logic dec_feat;

  logic [`VID_DATA_W-1:0] init_word;
  vid_store_wr_t st_wr;

  // version words as they are stored
  localparam logic [31:0] CTRL_WORD = {`VID_CTRL_TYPE_CODE, CTRL_VERSION};
  localparam logic [31:0] LOGIC_WORD = {CAMERA_TYPE, LOGIC_VERSION};
  localparam int N_BCD = 4;

  // BCD sanity per checked word; ext words may be all zero (absent)
  logic [N_BCD-1:0] bcd_ok;
  logic [31:0] bcd_word [N_BCD];
  assign bcd_word[0] = {16'h0000, CTRL_VERSION};
  assign bcd_word[1] = {16'h0000, LOGIC_VERSION};
  assign bcd_word[2] = CTRL_VERSION_EX;
  assign bcd_word[3] = LOGIC_VERSION_EX;

  genvar w;
  genvar n;
  generate
    for (w = 0; w < N_BCD; w++) begin : g_bcd
      logic [7:0] nib_ok;
      for (n = 0; n < 8; n++) begin : g_nib
        assign nib_ok[n] = (bcd_word[w][n*4 +: 4] <= `VID_NIBBLE_MAX);
      end
      assign bcd_ok[w] = &nib_ok;
    end
  endgenerate

  // word written into the store during the load walk
  always_comb begin
    init_word = `VID_ZERO_WORD;
    unique case (load_idx_r)
      `VID_IDX_CTRL_VER: init_word = CTRL_WORD;
      `VID_IDX_CTRL_VER_EX: init_word = CTRL_VERSION_EX;
      `VID_IDX_LOGIC_VER: init_word = LOGIC_WORD;
      `VID_IDX_LOGIC_VER_EX: init_word = LOGIC_VERSION_EX;
      `VID_IDX_ORDER_HI: init_word = ORDER_ID[63:32];
      `VID_IDX_ORDER_LO: init_word = ORDER_ID[31:0];
      default: init_word = `VID_ZERO_WORD;
    endcase
  end

  // address decode, shared by reads and writes; one item per word so
  // misaligned and unmapped addresses fall to the default and read zero
  always_comb begin
    dec_idx = '0;
    dec_hit = 1'b1;
    dec_rsvd = 1'b0;
    dec_feat = 1'b0;
    unique case (bus_req.addr)
      `VID_CTRL_VER_ADDR: begin
        dec_idx = `VID_IDX_CTRL_VER;
      end
      `VID_CTRL_VER_EX_ADDR: begin
        dec_idx = `VID_IDX_CTRL_VER_EX;
      end
      `VID_LOGIC_VER_ADDR: begin
        dec_idx = `VID_IDX_LOGIC_VER;
      end
      `VID_LOGIC_VER_EX_ADDR: begin
        dec_idx = `VID_IDX_LOGIC_VER_EX;
      end
      `VID_RSVD_A_ADDR: begin
        dec_idx = `VID_IDX_RSVD_A;
        dec_rsvd = 1'b1;
      end
      `VID_RSVD_B_ADDR: begin
        dec_idx = `VID_IDX_RSVD_B;
        dec_rsvd = 1'b1;
      end
      `VID_RSVD_C_ADDR: begin
        dec_idx = `VID_IDX_RSVD_C;
        dec_rsvd = 1'b1;
      end
      `VID_RSVD_D_ADDR: begin
        dec_idx = `VID_IDX_RSVD_D;
        dec_rsvd = 1'b1;
      end
      `VID_ORDER_HI_ADDR: begin
        dec_idx = `VID_IDX_ORDER_HI;
      end
      `VID_ORDER_LO_ADDR: begin
        dec_idx = `VID_IDX_ORDER_LO;
      end
      `VID_FEAT_CTRL_ADDR: begin
        dec_idx = `VID_IDX_FEAT_CTRL;
        dec_feat = 1'b1;
      end
      `VID_STATUS_ADDR: begin
        dec_idx = `VID_IDX_STATUS;
      end
      default: begin
        dec_hit = 1'b0;
      end
    endcase
  end

  // load walk: fill the store once after reset, then serve the bus
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      VID_ST_LOAD: begin
        if (load_idx_r == `VID_LOAD_LAST) begin
          state_nxt = VID_ST_RUN;
        end
      end
      VID_ST_RUN: begin
        state_nxt = VID_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= VID_ST_LOAD;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      load_idx_r <= '0;
    end else if ((state_r == VID_ST_LOAD) &&
                 (load_idx_r != `VID_LOAD_LAST)) begin
      load_idx_r <= load_idx_r + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      loaded_r <= 1'b0;
    end else if (state_r == VID_ST_LOAD && state_nxt == VID_ST_RUN) begin
      loaded_r <= 1'b1;
    end
  end

  // feature enable follows any write to the feature word, activated or not
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      feat_en_r <= 1'b0;
    end else if (bus_req.wr && dec_feat) begin
      feat_en_r <= bus_req.wdata[`VID_FEAT_ENABLE_BIT];
    end
  end

  always_comb begin
    status_nxt = `VID_STATUS_RESET;
    status_nxt[`VID_ST_CTRL_VER_OK] = bcd_ok[0];
    status_nxt[`VID_ST_LOGIC_VER_OK] = bcd_ok[1];
    status_nxt[`VID_ST_CTRL_EX_OK] = bcd_ok[2];
    status_nxt[`VID_ST_LOGIC_EX_OK] = bcd_ok[3];
    status_nxt[`VID_ST_CTRL_EX_SUP] = (CTRL_VERSION_EX != '0);
    status_nxt[`VID_ST_LOGIC_EX_SUP] = (LOGIC_VERSION_EX != '0);
    status_nxt[`VID_ST_LOADED] = loaded_r;
    status_nxt[`VID_ST_FEAT_EN] = feat_en_r;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_r <= `VID_STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  // a bus write to the feature word takes the single store port; status catches up next cycle
  // the flag clears only on a granted status write, so a copy that lost
  // the port to the seed or a bus write is never dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_dirty_r <= 1'b1;
    end else if (bus_req.wr && dec_feat) begin
      status_dirty_r <= 1'b1;
    end else if (status_r != status_nxt) begin
      status_dirty_r <= 1'b1;
    end else if (status_wr_go) begin
      status_dirty_r <= 1'b0;
    end
  end

  // store write arbitration
  always_comb begin
    st_wr.en = 1'b0;
    st_wr.idx = '0;
    st_wr.data = `VID_ZERO_WORD;
    status_wr_go = 1'b0;
    if (state_r == VID_ST_LOAD) begin
      st_wr.en = 1'b1;
      st_wr.idx = load_idx_r;
      st_wr.data = init_word;
    end else if (bus_req.wr && dec_feat) begin
      st_wr.en = 1'b1;
      st_wr.idx = `VID_IDX_FEAT_CTRL;
      st_wr.data = bus_req.wdata;
      st_wr.data[`VID_FEAT_PRESENT_BIT] = 1'b1;
    end else if (!feat_seeded_r) begin
      st_wr.en = 1'b1;
      st_wr.idx = `VID_IDX_FEAT_CTRL;
      st_wr.data = `VID_FEAT_CTRL_RESET;
    end else if (status_dirty_r) begin
      status_wr_go = 1'b1;
      st_wr.en = 1'b1;
      st_wr.idx = `VID_IDX_STATUS;
      st_wr.data = status_r;
    end
    // writes to version, order and reserved words fall through
  end

  // the seed waits for the run state so it never races the load walk
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      feat_seeded_r <= 1'b0;
    end else if (state_r == VID_ST_RUN) begin
      feat_seeded_r <= 1'b1;
    end
  end

  vid_word_store #(
    .WIDTH(`VID_DATA_W),
    .DEPTH(`VID_DEPTH),
    .IDX_W(`VID_IDX_W)
  ) u_store (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(st_wr.en),
    .wr_idx(st_wr.idx),
    .wr_data(st_wr.data),
    .rd_en(bus_req.rd),
    .rd_hit(dec_hit && !dec_rsvd),
    .rd_idx(dec_idx),
    .rd_data(bus_rdata)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      feature_enabled <= 1'b0;
    end else begin
      feature_enabled <= feat_en_r;
    end
  end

  assign loaded = loaded_r;

endmodule

// ---- src/vid_word_store.sv ----
// small word store for the identification register group.
// assumes one writer; read data come out of a register one cycle later.
`timescale 1ns/10ps
`include "vid_regs.svh"

module vid_word_store
  import vid_pkg::*;
#(
  parameter int WIDTH = `VID_DATA_W,
  parameter int DEPTH = `VID_DEPTH,
  parameter int IDX_W = `VID_IDX_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // write port
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  // read port
  input wire logic rd_en,
  input wire logic rd_hit,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] rd_data_r;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_word
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          mem_r[g] <= '0;
        end else if (wr_en && (wr_idx == IDX_W'(g))) begin
          mem_r[g] <= wr_data;
        end
      end
    end
  endgenerate

  // unmapped or idle cycles answer zero so stale data never leak out
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_r <= '0;
    end else if (rd_en && rd_hit && (int'(rd_idx) < DEPTH)) begin
      rd_data_r <= mem_r[rd_idx];
    end else begin
      rd_data_r <= '0;
    end
  end

  assign rd_data = rd_data_r;

endmodule

// ---- tb/vid_regs_sva.sv ----
// checker on the ports of vid_regs_top.
// assumes words are judged once loaded has stood three cycles.
`timescale 1ns/10ps
`include "vid_regs.svh"
module vid_regs_sva
  import vid_pkg::*;
#(
  parameter logic [15:0] CTRL_VERSION = 16'h0000,
  parameter logic [31:0] CTRL_VERSION_EX = 32'h00000000,
  parameter logic [15:0] CAMERA_TYPE = 16'h0000,
  parameter logic [15:0] LOGIC_VERSION = 16'h0000,
  parameter logic [31:0] LOGIC_VERSION_EX = 32'h00000000,
  parameter logic [63:0] ORDER_ID = 64'h0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register bus and status
  input wire vid_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic loaded,
  input wire logic feature_enabled
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // the feature word is seeded after loaded rises, so wait a little
  logic [2:0] up_r;
  always_ff @(posedge sys_clk) up_r <= rst ? 3'h0 : {up_r[1:0], loaded};
  wire rdy = &up_r & loaded;
  wire rd_c = bus_req.rd & rdy;
  wire [31:0] a = bus_req.addr;
  rdata_idle_a:
    assert property (!bus_req.rd |=> bus_rdata == 32'h00000000)
    else $error("read data not zero when idle");
  ctrl_word_a:
    assert property (rd_c && a == `VID_CTRL_VER_ADDR |=>
      bus_rdata == {16'h0000, CTRL_VERSION}) else $error("ctrl word");
  ctrl_ext_a:
    assert property (rd_c && a == `VID_CTRL_VER_EX_ADDR |=>
      bus_rdata == CTRL_VERSION_EX) else $error("ctrl ext word");
  logic_word_a:
    assert property (rd_c && a == `VID_LOGIC_VER_ADDR |=>
      bus_rdata == {CAMERA_TYPE, LOGIC_VERSION}) else $error("logic word");
  logic_ext_a:
    assert property (rd_c && a == `VID_LOGIC_VER_EX_ADDR |=>
      bus_rdata == LOGIC_VERSION_EX) else $error("logic ext word");
  reserved_zero_a:
    assert property (rd_c && a >= `VID_RSVD_A_ADDR && a <= `VID_RSVD_D_ADDR
      |=> bus_rdata == 32'h00000000) else $error("reserved not zero");
  order_id_a:
    assert property (rd_c && a == `VID_ORDER_HI_ADDR |=>
      bus_rdata == ORDER_ID[63:32]) else $error("order high word");
  feat_present_a:
    assert property (rd_c && a == `VID_FEAT_CTRL_ADDR |=> bus_rdata[0])
    else $error("presence bit low");
  feat_write_a:
    assert property (bus_req.wr && rdy && a == `VID_FEAT_CTRL_ADDR |->
      ##2 feature_enabled == $past(bus_req.wdata[1], 2))
    else $error("enable did not follow write");
  cover property (rd_c && a == `VID_ORDER_LO_ADDR);
  cover property (bus_req.wr && rdy && a == `VID_CTRL_VER_ADDR);
  cover property (bus_req.wr && rdy && a == `VID_FEAT_CTRL_ADDR);
endmodule
bind vid_regs_top vid_regs_sva #(.CTRL_VERSION(CTRL_VERSION),
  .CTRL_VERSION_EX(CTRL_VERSION_EX), .CAMERA_TYPE(CAMERA_TYPE),
  .LOGIC_VERSION(LOGIC_VERSION), .LOGIC_VERSION_EX(LOGIC_VERSION_EX),
  .ORDER_ID(ORDER_ID)) u_sva (.sys_clk(sys_clk), .rst(rst),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .loaded(loaded),
  .feature_enabled(feature_enabled));

// ---- tb/vid_regs_top_tb.sv ----
// bench for the identification word group.
// assumes the strobe bus of the notes; a second copy has no ext words.
`timescale 1ns/10ps
`include "vid_regs.svh"
module vid_regs_top_tb
  import vid_pkg::*;
;
  localparam logic [31:0] CVX = 32'h00223344;
  localparam logic [31:0] LVX = 32'h01020304;
  // arbitrary type code and order text
  localparam logic [15:0] CT = 16'h0C5E;
  localparam logic [63:0] OID = 64'h5445535449443432;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  vid_bus_req_t bus_req = '0;
  logic [31:0] rdata, rdata2, got2;
  logic loaded, feat_en;
  int errors = 0;
  int comparisons = 0;
  logic [31:0] exp_w [10];
  always #12.5 sys_clk = ~sys_clk;
  vid_regs_top #(.CTRL_VERSION(16'h0085), .CTRL_VERSION_EX(CVX),
    .CAMERA_TYPE(CT), .LOGIC_VERSION(16'h0110), .LOGIC_VERSION_EX(LVX),
    .ORDER_ID(OID)) DUT (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req),
    .bus_rdata(rdata), .loaded(loaded), .feature_enabled(feat_en));
  vid_regs_top #(.CTRL_VERSION(16'h0085), .CTRL_VERSION_EX(32'h0),
    .CAMERA_TYPE(CT), .LOGIC_VERSION(16'h0110), .LOGIC_VERSION_EX(32'h0),
    .ORDER_ID(OID))
    DUT_noex (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req),
    .bus_rdata(rdata2), .loaded(), .feature_enabled());
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    got2 = rdata2;
    check(rdata, exp);
  endtask
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    exp_w = '{{16'h0000, 16'h0085}, CVX, {CT, 16'h0110}, LVX, 32'h0,
      32'h0, 32'h0, 32'h0, OID[63:32], OID[31:0]};
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    check({rdata[31:1], rdata[0] | loaded | feat_en}, 32'h0);
    // the load walk is short; a hang here ends the run
    for (int i = 0; i < 40 && loaded !== 1'b1; i++) @(posedge sys_clk);
    if (loaded !== 1'b1) begin
      errors++;
      close_out();
    end
    repeat (4) @(posedge sys_clk);
    $display("reset test done");
    // second pass tries to overwrite each version, reserved and order word first
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 10; i++) begin
        if (p == 1) wr(`VID_BASE_ADDR + 4 * i, ~exp_w[i]);
        rd(`VID_BASE_ADDR + 4 * i, exp_w[i]);
        check(got2, (i == 1 || i == 3) ? 32'h0 : exp_w[i]);
      end
      $display("word pass %0d done", p);
    end
    wr(32'hF1000038, 32'hFFFFFFFF);
    rd(32'hF1000038, 32'h0);
    rd(`VID_STATUS_ADDR, 32'h0000007F);
    check(got2, 32'h0000004F);
    rd(`VID_FEAT_CTRL_ADDR, 32'h00000001);
    wr(`VID_FEAT_CTRL_ADDR, 32'h00000002);
    rd(`VID_FEAT_CTRL_ADDR, 32'h00000003);
    check({31'h0, feat_en}, 32'h1);
    wr(`VID_FEAT_CTRL_ADDR, 32'h0);
    rd(`VID_FEAT_CTRL_ADDR, 32'h00000001);
    check({31'h0, feat_en}, 32'h0);
    $display("feature test done");
    close_out();
  end
endmodule
